// [pts_pkg.sv]
package pts_pkg;

	// Step byte layout
	localparam int OP_MSB = 7;
	localparam int OP_LSB = 4;
	localparam int ARG_MSB = 3;
	localparam int ARG_LSB = 0;

	// Opcodes (upper nibble; the 3-bit ones match its top three bits)
	localparam logic [3:0] OP_CONTROL = 4'h0;
	localparam logic [3:0] OP_ADD = 4'h1;
	localparam logic [2:0] OP_STROBE = 3'h1;
	localparam logic [3:0] OP_WAIT_RISE = 4'h4;
	localparam logic [3:0] OP_WAIT_FALL = 4'h5;
	localparam logic [3:0] OP_RESERVED = 4'h6;
	localparam logic [3:0] OP_IRQ = 4'h7;
	localparam logic [2:0] OP_TRIG = 3'h4;
	localparam logic [2:0] OP_JUMP = 3'h5;
	localparam logic [2:0] OP_LOOP_A = 3'h6;
	localparam logic [2:0] OP_LOOP_B = 3'h7;

	// Control-step options
	localparam logic [3:0] CTL_NOP = 4'h0;
	localparam logic [3:0] CTL_COPY = 4'h1;
	localparam logic [3:0] CTL_WAIT_T0 = 4'h8;
	localparam logic [3:0] CTL_WAIT_T1 = 4'h9;
	localparam logic [3:0] CTL_CLR_T0 = 4'ha;
	localparam logic [3:0] CTL_CLR_T1 = 4'hb;
	localparam logic [3:0] CTL_CLR_CA = 4'hc;
	localparam logic [3:0] CTL_CLR_CB = 4'hd;

	// Add-step targets
	localparam logic [3:0] TGT_LIMIT_T0 = 4'h0;
	localparam logic [3:0] TGT_LIMIT_T1 = 4'h1;
	localparam logic [3:0] TGT_LIMIT_A = 4'h2;
	localparam logic [3:0] TGT_LIMIT_B = 4'h3;

	// Reset values
	localparam logic [4:0] PTR_RESET = 5'h00;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [7:0] STEP_RESET = 8'h60;

	// Watchdog
	localparam int WDOG_TIME_US = 100;
	localparam int CLK_MHZ = 20;
	localparam int WDOG_CYCLES = WDOG_TIME_US * CLK_MHZ;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_WAIT = 3'b100
	} pts_state_t;

endpackage

// [pts_edge_if.sv]
interface pts_edge_if #(parameter int NTRIG = 16);
	logic [NTRIG-1:0] rise;
	logic [NTRIG-1:0] fall;
	modport src (output rise, output fall);
	modport dst (input rise, input fall);
endinterface

// [pts_edge_detect.sv]
module pts_edge_detect
	import pts_pkg::*;
#(
	parameter int NTRIG = 16
)
(
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [NTRIG-1:0] trigIn,
	pts_edge_if.src               edges
);
	logic [NTRIG-1:0] sync1_q;
	logic [NTRIG-1:0] sync2_q;
	logic [NTRIG-1:0] sync3_q;
	logic [NTRIG-1:0] level_q;
	logic [NTRIG-1:0] agree;

	// Three-stage synchroniser
	always_ff @(posedge clk)
	begin
		sync1_q <= trigIn;
		sync2_q <= sync1_q;
		sync3_q <= sync2_q;
	end

	// Level changes only when stages two and three agree
	assign agree = ~(sync2_q ^ sync3_q);

	always_ff @(posedge clk)
	begin
		if (srst)
			level_q <= '0;
		else
			level_q <= (agree & sync3_q) | (~agree & level_q);
	end

	// One-cycle edge pulses
	assign edges.rise = agree & sync3_q & ~level_q;
	assign edges.fall = agree & ~sync3_q & level_q;
endmodule

// [pts_trigger_sequencer.sv]
module pts_trigger_sequencer
	import pts_pkg::*;
#(
	parameter int NTRIG       = 16,
	parameter int NOUT        = 32,
	parameter int QDEPTH      = 32,
	parameter int WDOG_CYCLES_P = WDOG_CYCLES
)
(
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              enable,
	input  wire logic              singleStep,
	input  wire logic              edgeInvert,
	input  wire logic              queueWrite,
	input  wire logic [4:0]        queueAddr,
	input  wire logic [7:0]        queueData,
	input  wire logic [15:0]       adjustValue,
	input  wire logic [15:0]       holdValue,
	input  wire logic [15:0]       loopLimitA,
	input  wire logic [15:0]       loopLimitB,
	input  wire logic [15:0]       timerLimit0In,
	input  wire logic [15:0]       timerLimit1In,
	input  wire logic              limitLoad,
	input  wire logic [NTRIG-1:0]  trigIn,
	output logic [NOUT-1:0]        trigOut,
	output logic [3:0]             irqOut,
	output logic                   stepIrq,
	output logic                   wdogIrq,
	output logic [4:0]             converterInputSelect,
	output logic [4:0]             stepPointer,
	output logic                   busy,
	output logic [15:0]            loopCounterA,
	output logic [15:0]            loopCounterB
);
	pts_edge_if #(.NTRIG(NTRIG)) edgeBus ();

	logic [7:0]       queue_q [QDEPTH];
	pts_state_t       state_q;
	pts_state_t       state_d;
	logic [4:0]       ptr_q;
	logic [4:0]       ptr_d;
	logic [7:0]       step_q;
	logic [15:0]      timer0_q;
	logic [15:0]      timer1_q;
	logic [15:0]      tlim0_q;
	logic [15:0]      tlim1_q;
	logic [15:0]      cntA_q;
	logic [15:0]      cntB_q;
	logic [15:0]      limA_q;
	logic [15:0]      limB_q;
	logic [$clog2(WDOG_CYCLES_P+1)-1:0] wdog_q;
	logic             waitRise_q;
	logic [3:0]       waitSel_q;
	logic [1:0]       waitTimer_q;

	logic [3:0]       opc;
	logic [3:0]       arg;
	logic [4:0]       wide;
	logic             isJump;
	logic             takeA;
	logic             takeB;
	logic             isTimerWait;
	logic [NTRIG-1:0] riseSel;
	logic [NTRIG-1:0] fallSel;
	logic             edgeHit;
	logic             timerHit;
	logic             waitDone;
	logic             execNow;
	logic             wdogFire;
	logic             stepAdvance;
	logic             waitLeave;
	logic [4:0]       ptrNext;

	// Add or copy a value into the selected limit
	function automatic logic [15:0] pick(input logic [3:0] tgt, input logic [3:0] want,
		input logic [15:0] cur, input logic [15:0] val, input logic add);
		logic [15:0] r;
		r = cur;
		if (tgt == want)
			r = add ? 16'(cur + val) : val;
		return r;
	endfunction

	pts_edge_detect #(.NTRIG(NTRIG)) uEdge
	(
		.clk    (clk),
		.srst   (srst),
		.trigIn (trigIn),
		.edges  (edgeBus.src)
	);

	// Step decode
	assign opc = step_q[OP_MSB:OP_LSB];
	assign arg = step_q[ARG_MSB:ARG_LSB];
	assign wide = {opc[0], arg};
	assign takeA = (opc[3:1] == OP_LOOP_A) && (cntA_q != limA_q);
	assign takeB = (opc[3:1] == OP_LOOP_B) && (cntB_q != limB_q);
	assign isJump = (opc[3:1] == OP_JUMP) || takeA || takeB;
	assign isTimerWait = (opc == OP_CONTROL)
		&& (arg == CTL_WAIT_T0 || arg == CTL_WAIT_T1);

	// Edge polarity select
	assign riseSel = edgeInvert ? edgeBus.fall : edgeBus.rise;
	assign fallSel = edgeInvert ? edgeBus.rise : edgeBus.fall;
	assign edgeHit = waitRise_q ? riseSel[waitSel_q] : fallSel[waitSel_q];
	assign timerHit = (waitTimer_q[0] && timer0_q >= tlim0_q)
		|| (waitTimer_q[1] && timer1_q >= tlim1_q);
	assign waitDone = (waitTimer_q != 2'b00) ? timerHit : edgeHit;
	assign execNow = (state_q == ST_EXEC);
	assign wdogFire = (state_q == ST_WAIT)
		&& (wdog_q == ($clog2(WDOG_CYCLES_P+1))'(WDOG_CYCLES_P));

	// Next pointer
	assign ptr_d = isJump ? wide : 5'(ptr_q + 5'h01);

	// Pointer of the coming cycle; the fetch follows it so a finished wait is not rerun
	assign stepAdvance = execNow && opc != OP_WAIT_RISE && opc != OP_WAIT_FALL && !isTimerWait;
	assign waitLeave = (state_q == ST_WAIT) && waitDone;
	assign ptrNext = stepAdvance ? ptr_d
		: (waitLeave ? 5'(ptr_q + 5'h01) : ptr_q);

	// Sequencer state
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (enable)
					state_d = ST_EXEC;
			ST_EXEC:
				if (!enable)
					state_d = ST_IDLE;
				else if (opc == OP_WAIT_RISE || opc == OP_WAIT_FALL || isTimerWait)
					state_d = ST_WAIT;
				else if (singleStep)
					state_d = ST_IDLE;
			ST_WAIT:
				if (!enable || wdogFire)
					state_d = ST_IDLE;
				else if (waitDone)
					state_d = singleStep ? ST_IDLE : ST_EXEC;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Queue storage written by software
	always_ff @(posedge clk)
	begin
		if (queueWrite)
			queue_q[queueAddr] <= queueData;
	end

	// Pointer and fetched step
	always_ff @(posedge clk)
	begin
		if (srst)
			ptr_q <= PTR_RESET;
		else
			ptr_q <= ptrNext;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			step_q <= STEP_RESET;
		else
			step_q <= queue_q[ptrNext];
	end

	// Wait capture
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			waitRise_q  <= 1'b0;
			waitSel_q   <= 4'h0;
			waitTimer_q <= 2'b00;
		end
		else if (execNow)
		begin
			waitRise_q  <= (opc == OP_WAIT_RISE);
			waitSel_q   <= arg;
			waitTimer_q <= isTimerWait ? {arg == CTL_WAIT_T1, arg == CTL_WAIT_T0} : 2'b00;
		end
	end

	// Timers count every cycle; each timer's own clear and timer-wait steps restart it
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			timer0_q <= CNT_RESET;
			timer1_q <= CNT_RESET;
		end
		else
		begin
			timer0_q <= (execNow && (arg == CTL_CLR_T0 || arg == CTL_WAIT_T0) && opc == OP_CONTROL)
				? CNT_RESET : 16'(timer0_q + 16'h0001);
			timer1_q <= (execNow && (arg == CTL_CLR_T1 || arg == CTL_WAIT_T1) && opc == OP_CONTROL)
				? CNT_RESET : 16'(timer1_q + 16'h0001);
		end
	end

	// Limits: loaded by software, adjusted by add and copy steps
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tlim0_q <= CNT_RESET;
			tlim1_q <= CNT_RESET;
			limA_q  <= CNT_RESET;
			limB_q  <= CNT_RESET;
		end
		else if (limitLoad)
		begin
			tlim0_q <= timerLimit0In;
			tlim1_q <= timerLimit1In;
			limA_q  <= loopLimitA;
			limB_q  <= loopLimitB;
		end
		else if (execNow && opc == OP_ADD)
		begin
			tlim0_q <= pick(arg, TGT_LIMIT_T0, tlim0_q, adjustValue, 1'b1);
			tlim1_q <= pick(arg, TGT_LIMIT_T1, tlim1_q, adjustValue, 1'b1);
			limA_q  <= pick(arg, TGT_LIMIT_A, limA_q, adjustValue, 1'b1);
			limB_q  <= pick(arg, TGT_LIMIT_B, limB_q, adjustValue, 1'b1);
		end
		else if (execNow && opc == OP_CONTROL && arg == CTL_COPY)
		begin
			tlim0_q <= holdValue;
			tlim1_q <= holdValue;
		end
	end

	// Loop counters
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cntA_q <= CNT_RESET;
			cntB_q <= CNT_RESET;
		end
		else if (execNow)
		begin
			if (takeA)
				cntA_q <= 16'(cntA_q + 16'h0001);
			else if (opc == OP_CONTROL && arg == CTL_CLR_CA)
				cntA_q <= CNT_RESET;
			if (takeB)
				cntB_q <= 16'(cntB_q + 16'h0001);
			else if (opc == OP_CONTROL && arg == CTL_CLR_CB)
				cntB_q <= CNT_RESET;
		end
	end

	// Watchdog counts wait cycles
	always_ff @(posedge clk)
	begin
		if (srst || state_q != ST_WAIT)
			wdog_q <= '0;
		else if (!wdogFire)
			wdog_q <= wdog_q + 1'b1;
	end

	// Pulsed outputs and held input select, reserved codes fall through as no-ops
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			trigOut <= '0;
			irqOut  <= 4'h0;
			stepIrq <= 1'b0;
			wdogIrq <= 1'b0;
			converterInputSelect <= 5'h00;
		end
		else
		begin
			trigOut <= '0;
			irqOut  <= 4'h0;
			if (execNow && opc[3:1] == OP_TRIG)
				trigOut[wide] <= 1'b1;
			if (execNow && opc == OP_IRQ && arg < 4'h4)
				irqOut[arg[1:0]] <= 1'b1;
			if (execNow && opc[3:1] == OP_STROBE)
				converterInputSelect <= wide;
			stepIrq <= singleStep && ((execNow && state_d != ST_WAIT)
				|| (state_q == ST_WAIT && waitDone));
			wdogIrq <= wdogFire;
		end
	end

	// Status mirrors
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			stepPointer  <= PTR_RESET;
			busy         <= 1'b0;
			loopCounterA <= CNT_RESET;
			loopCounterB <= CNT_RESET;
		end
		else
		begin
			stepPointer  <= ptr_q;
			busy         <= (state_q != ST_IDLE);
			loopCounterA <= cntA_q;
			loopCounterB <= cntB_q;
		end
	end
endmodule

// [pts_properties.sv]
module pts_properties
	import pts_pkg::*;
#(
	parameter int NOUT = 32
)
(
	input wire logic            clk,
	input wire logic            srst,
	input wire logic            singleStep,
	input wire logic [NOUT-1:0] trigOut,
	input wire logic [3:0]      irqOut,
	input wire logic            stepIrq,
	input wire logic            wdogIrq,
	input wire logic [4:0]      converterInputSelect,
	input wire logic [4:0]      stepPointer,
	input wire logic            busy,
	input wire logic [15:0]     loopCounterA
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// Two watchdog pulses in a row
	sequence wdog_burst;
		wdogIrq ##1 wdogIrq;
	endsequence

	// Output pulses, counters and status
	a_trig_one_hot: assert property ($onehot0(trigOut))
		else $error("several trigger outputs at once");
	a_irq_one_hot: assert property ($onehot0(irqOut))
		else $error("several interrupt outputs at once");
	a_reset_clears: assert property ($fell(srst) |-> loopCounterA == 16'h0000 && stepPointer == 5'h00 && trigOut == '0)
		else $error("state not cleared by reset");
	a_count_a_step: assert property ($changed(loopCounterA) |-> loopCounterA == $past(loopCounterA) + 16'h0001 || loopCounterA == 16'h0000)
		else $error("loop counter jumped");
	a_sel_needs_busy: assert property ($changed(converterInputSelect) |-> busy)
		else $error("input select changed while idle");
	a_step_irq_cause: assert property (stepIrq |-> $past(singleStep) || $past(singleStep, 2))
		else $error("step interrupt outside single-step mode");
	a_wdog_single: assert property (not wdog_burst)
		else $error("watchdog pulse too long");
	a_wdog_cause: assert property (wdogIrq |-> $past(busy))
		else $error("watchdog pulse while idle");
endmodule

bind pts_trigger_sequencer pts_properties #(.NOUT(NOUT)) pts_properties_i (.clk(clk), .srst(srst),
	.singleStep(singleStep), .trigOut(trigOut), .irqOut(irqOut), .stepIrq(stepIrq),
	.wdogIrq(wdogIrq), .converterInputSelect(converterInputSelect), .stepPointer(stepPointer),
	.busy(busy), .loopCounterA(loopCounterA));

// [pts_periph_model.sv]
module pts_periph_model
(
	input  wire logic        clk,
	input  wire logic        fire,
	input  wire logic [3:0]  fireIdx,
	output logic      [15:0] trigIn
);
	timeunit 1ns;
	timeprecision 1ns;
	int hold = 0;
	initial trigIn = 16'h0000;
	// Chosen line high a few cycles, all lines low otherwise
	always @(posedge clk)
	begin
		if (fire)
		begin
			trigIn <= 16'h0001 << fireIdx;
			hold <= 6;
		end
		else if (hold > 1)
			hold <= hold - 1;
		else
			trigIn <= 16'h0000;
	end
endmodule

// [pts_trigger_sequencer_bench.sv]
module pts_trigger_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import pts_pkg::*;
	localparam int WDOG = 40;
	logic        clk = 1'b0;
	logic        srst, enable, singleStep, edgeInvert, queueWrite, limitLoad, fire;
	logic [4:0]  queueAddr, converterInputSelect, stepPointer;
	logic [7:0]  queueData;
	logic [3:0]  fireIdx, irqOut, irqSeen;
	logic [15:0] loopLimitA, loopLimitB, adjustValue, holdValue;
	logic [15:0] trigIn, loopCounterA, loopCounterB;
	logic [31:0] trigOut, trigSeen;
	logic        stepIrq, wdogIrq, busy, stepSeen, wdogSeen;
	int          trig0Count, mismatches = 0, samples_checked = 0, cycles = 0;

	pts_trigger_sequencer #(.WDOG_CYCLES_P(WDOG)) pts_trigger_sequencer_i (.clk(clk), .srst(srst),
		.enable(enable), .singleStep(singleStep), .edgeInvert(edgeInvert),
		.queueWrite(queueWrite), .queueAddr(queueAddr), .queueData(queueData),
		.adjustValue(adjustValue), .holdValue(holdValue), .loopLimitA(loopLimitA),
		.loopLimitB(loopLimitB), .timerLimit0In(16'h0000), .timerLimit1In(16'h0000),
		.limitLoad(limitLoad), .trigIn(trigIn), .trigOut(trigOut), .irqOut(irqOut),
		.stepIrq(stepIrq), .wdogIrq(wdogIrq), .converterInputSelect(converterInputSelect),
		.stepPointer(stepPointer), .busy(busy), .loopCounterA(loopCounterA),
		.loopCounterB(loopCounterB));
	pts_periph_model pts_periph_model_i (.clk(clk), .fire(fire), .fireIdx(fireIdx), .trigIn(trigIn));

	always #25 clk = ~clk;

	// Collect output pulses and cut a hang short
	always @(posedge clk)
	begin
		cycles++;
		trigSeen |= trigOut;
		irqSeen |= irqOut;
		stepSeen |= stepIrq;
		wdogSeen |= wdogIrq;
		if (trigOut[0] === 1'b1)
			trig0Count++;
		if (cycles == 3000)
		begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic rst;
		srst = 1'b1;
		enable = 1'b0;
		tick(10);
		srst = 1'b0;
		trigSeen = '0;
		irqSeen = '0;
		stepSeen = 1'b0;
		wdogSeen = 1'b0;
		trig0Count = 0;
	endtask

	// Queue written while stopped, write strobe held across entries
	task automatic load(input logic [7:0] p[]);
		queueWrite = 1'b1;
		foreach (p[i])
		begin
			queueAddr = 5'(i);
			queueData = p[i];
			tick(1);
		end
		queueWrite = 1'b0;
	endtask

	task automatic wait_ptr(input logic [4:0] p);
		for (int i = 0; i < 60 && stepPointer !== p; i++)
			tick(1);
	endtask

	// One trigger pulse from the peripheral model, back after its rise has passed
	task automatic pulse(input logic [3:0] idx);
		fireIdx = idx;
		fire = 1'b1;
		tick(1);
		fire = 1'b0;
		tick(5);
	endtask

	task automatic t_run;
		rst();
		load('{8'h23, 8'h85, 8'h71, 8'h60, 8'h75, 8'h40, 8'h91, 8'ha7});
		enable = 1'b1;
		wait_ptr(5'h05);
		tick(8);
		chk(stepPointer, 5'h05, "wait step left early");
		chk(converterInputSelect, 5'h03, "input select");
		chk(irqSeen, 4'h2, "interrupt outputs");
		chk(trigSeen, 32'h0000_0020, "trigger before wait");
		pulse(4'h0);
		wait_ptr(5'h07);
		tick(3);
		chk(stepPointer, 5'h07, "jump target");
		chk(trigSeen, 32'h0002_0020, "trigger after wait");
		chk(irqSeen, 4'h2, "reserved steps had effect");
	endtask

	task automatic t_loop;
		rst();
		limitLoad = 1'b1;
		tick(1);
		limitLoad = 1'b0;
		load('{8'h80, 8'hc0, 8'ha2});
		enable = 1'b1;
		wait_ptr(5'h02);
		tick(3);
		chk(32'(trig0Count), 32'd3, "loop passes");
		chk(loopCounterA, 16'h0002, "loop counter");
	endtask

	// Add raises limit A, counted jump B reruns the inner loop once
	task automatic t_count;
		rst();
		limitLoad = 1'b1;
		tick(1);
		limitLoad = 1'b0;
		load('{8'h12, 8'h80, 8'hc1, 8'h0c, 8'he1, 8'ha5});
		enable = 1'b1;
		wait_ptr(5'h03);
		chk(32'(trig0Count), 32'd4, "adjusted limit");
		chk(loopCounterA, 16'h0003, "counter at limit");
		wait_ptr(5'h05);
		tick(3);
		chk(32'(trig0Count), 32'd8, "counted passes");
		chk(loopCounterA, 16'h0000, "counter clear");
		chk(loopCounterB, 16'h0001, "second counter");
	endtask

	// Copied hold value sets how long the timer wait lasts
	task automatic t_timer;
		rst();
		load('{8'h01, 8'h08, 8'h80, 8'ha3});
		enable = 1'b1;
		tick(10);
		chk(trigSeen, 32'h0000_0000, "timer wait too short");
		tick(8);
		chk(trigSeen, 32'h0000_0001, "timer wait end");
	endtask

	// Fall wait ignores a rise; inverted polarity swaps the edges
	task automatic t_fall;
		rst();
		load('{8'h52, 8'h82, 8'h42, 8'h83, 8'ha4});
		enable = 1'b1;
		tick(4);
		pulse(4'h2);
		chk(trigSeen, 32'h0000_0000, "fall wait ended on rise");
		tick(8);
		chk(trigSeen, 32'h0000_0004, "fall wait end");
		edgeInvert = 1'b1;
		pulse(4'h2);
		chk(trigSeen, 32'h0000_0004, "inverted wait ended on rise");
		tick(8);
		chk(trigSeen, 32'h0000_000c, "inverted wait end");
		edgeInvert = 1'b0;
	endtask

	task automatic t_wdog;
		rst();
		load('{8'h41});
		enable = 1'b1;
		for (int i = 0; i < WDOG + 40 && !wdogSeen; i++)
			tick(1);
		chk(busy, 1'b0, "watchdog abort");
		tick(3);
		chk(wdogSeen, 1'b1, "watchdog interrupt");
	endtask

	task automatic t_single;
		rst();
		load('{8'h60, 8'h60, 8'ha2});
		singleStep = 1'b1;
		enable = 1'b1;
		tick(12);
		chk(stepSeen, 1'b1, "step interrupt");
		singleStep = 1'b0;
	endtask

	task automatic end_of_test;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Inputs at time zero, then the scenarios
	initial
	begin
		srst = 1'b1;
		enable = 1'b0;
		singleStep = 1'b0;
		edgeInvert = 1'b0;
		queueWrite = 1'b0;
		queueAddr = 5'h00;
		queueData = 8'h00;
		limitLoad = 1'b0;
		loopLimitA = 16'h0002;
		loopLimitB = 16'h0001;
		adjustValue = 16'h0001;
		holdValue = 16'h000a;
		fire = 1'b0;
		fireIdx = 4'h0;
		#2;
		t_run();
		t_loop();
		t_count();
		t_timer();
		t_fall();
		t_wdog();
		t_single();
		end_of_test();
	end
endmodule
